// >>> rtl/vbi_capture_pkg.sv
package vbi_capture_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_WIDESCREEN_A = 8'h08;
  localparam logic [7:0] OFF_WIDESCREEN_B = 8'h0C;
  localparam logic [7:0] OFF_WIDESCREEN_C = 8'h10;
  localparam logic [7:0] OFF_CAPTION_FIRST = 8'h14;
  localparam logic [7:0] OFF_CAPTION_SECOND = 8'h18;
  localparam logic [7:0] OFF_CAPTION_LINE = 8'h1C;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTL_VPS_EN = 0;
  localparam int CTL_WSS_EN = 1;
  localparam int CTL_CC_EN = 2;
  localparam int CTL_CC_IRQ_EN = 3;
  localparam int CTL_MODE_525 = 4;
  localparam int CTL_WIDTH = 5;
  localparam logic [4:0] CTL_RESET = 5'h00;

  // ****************************************
  // Flag register fields
  // ****************************************
  localparam int FLG_PAGE_LINK = 0;
  localparam int FLG_SERVICE = 1;
  localparam int FLG_VPS_RCV = 2;
  localparam int FLG_WSS_RCV = 3;
  localparam int FLG_COUNT = 4;

  // ****************************************
  // Line numbers, packets and memory places
  // ****************************************
  localparam logic [8:0] VPS_LINE = 9'h010;
  localparam logic [8:0] WSS_LINE = 9'h017;
  localparam logic [4:0] CC_LINE_RESET = 5'h15;
  localparam logic [4:0] PKT_PAGE_LINK = 5'h1B;
  localparam logic [4:0] PKT_SERVICE = 5'h1E;
  localparam logic [4:0] DESIG_PAGE_LINK = 5'h00;
  localparam logic [2:0] MAG_SERVICE_625 = 3'h0;
  localparam logic [1:0] MAG_SERVICE_525 = 2'h0;
  localparam logic [3:0] VPS_BLOCK = 4'h9;
  localparam logic [4:0] VPS_ROW = 5'h19;
  localparam int VPS_ERR_BIT = 4;

  // ****************************************
  // Widescreen grouping
  // ****************************************
  localparam int WSS_BITS = 14;
  localparam int WSS_A_LO = 0;
  localparam int WSS_A_W = 4;
  localparam int WSS_B_LO = 4;
  localparam int WSS_B_W = 4;
  localparam int WSS_C_LO = 8;
  localparam int WSS_C_W = 6;

endpackage

// >>> rtl/sticky_flag_bank.sv
`timescale 1ns/100ps

module sticky_flag_bank #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Hardware events and software clear
  input wire logic [N-1:0] i_set,
  input wire logic i_write,
  input wire logic [N-1:0] i_write_data,
  // Flag state
  output logic [N-1:0] o_flags
);

  typedef struct packed {
    logic [N-1:0] flags;
  } state_s;

  state_s state_reg;
  state_s state_next;

  always_comb begin
    state_next = state_reg;
    // Writing a zero clears a flag, a one leaves it alone
    if (i_write) begin
      state_next.flags = state_reg.flags & i_write_data;
    end
    // Same-cycle event beats the clear
    state_next.flags = state_next.flags | i_set;
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '0;
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  assign o_flags = state_reg.flags;

endmodule

// >>> rtl/vbi_side_data_capture.sv
`timescale 1ns/100ps

module vbi_side_data_capture
  import vbi_capture_pkg::*;
#(
  parameter int COL_W = 6
) (
  // Clock, reset, enable
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Slicer line timing
  input wire logic i_line_start,
  input wire logic i_line_end,
  input wire logic [8:0] i_line_num,
  input wire logic i_field,
  // Slicer run-in kind and raw line bytes
  input wire logic i_runin_vps,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  // Slicer decoded teletext packet address
  input wire logic i_pkt_valid,
  input wire logic [2:0] i_pkt_mag,
  input wire logic i_pkt_tab,
  input wire logic [4:0] i_pkt_num,
  input wire logic [4:0] i_pkt_desig,
  // Slicer widescreen word
  input wire logic i_wss_valid,
  input wire logic [13:0] i_wss_bits,
  input wire logic [13:0] i_wss_err,
  // Page memory write port
  output logic o_mem_we,
  output logic [3:0] o_mem_block,
  output logic [4:0] o_mem_row,
  output logic [COL_W-1:0] o_mem_col,
  output logic [7:0] o_mem_data,
  // Caption interrupt request
  output logic o_caption_irq
);

  // ****************************************
  // Helpers
  // ****************************************
  // Chip pair 10 is a one, 01 a zero; anything else is a biphase error
  function automatic logic [4:0] biphase_decode(input logic [7:0] chips);
    logic [4:0] res;
    res = '0;
    for (int i = 0; i < 4; i++) begin
      res[i] = chips[2*i+1];
      if (chips[2*i+1] == chips[2*i]) begin
        res[VPS_ERR_BIT] = 1'b1;
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] pack_group(input logic [5:0] bits, input logic err, input int width);
    logic [7:0] res;
    res = '0;
    for (int i = 0; i < 6; i++) begin
      if (i < width) begin
        res[i] = bits[i];
      end
    end
    res[7] = err;
    return res;
  endfunction

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    LINE_IDLE,
    LINE_VPS,
    LINE_CAPTION,
    LINE_OTHER
  } line_e;

  typedef struct packed {
    logic [CTL_WIDTH-1:0] control;
    logic [4:0] cc_line_sel;
    logic [7:0] wss_a;
    logic [7:0] wss_b;
    logic [7:0] wss_c;
    logic [7:0] cc_first;
    logic [7:0] cc_second;
    logic [1:0] cc_count;
    line_e line_state;
    logic vps_got;
    logic [COL_W-1:0] vps_col;
    logic mem_we;
    logic [COL_W-1:0] mem_col;
    logic [7:0] mem_data;
    logic [3:0] mem_block;
    logic [4:0] mem_row;
    logic irq;
    logic [31:0] readdata;
    logic waitrequest;
  } state_s;

  state_s state_reg;
  state_s state_next;
  logic [FLG_COUNT-1:0] flag_set;
  logic [FLG_COUNT-1:0] flags;
  logic access;
  logic done;
  logic flag_write;
  logic is_vps_line;
  logic is_cc_line;
  logic [4:0] vps_dec;
  logic wss_take;

  assign access = i_avs_read | i_avs_write;
  // A transfer completes at the edge where waitrequest is seen low
  assign done = access & ~state_reg.waitrequest;
  assign flag_write = done & i_avs_write & i_avs_byteenable[0] & (i_avs_address == OFF_FLAGS);
  assign is_vps_line = (i_line_num == VPS_LINE) & ~i_field;
  assign is_cc_line = (i_line_num == {4'h0, state_reg.cc_line_sel});
  assign vps_dec = biphase_decode(i_byte);
  // One decode feeds both the flag and the stored groups, so they never disagree
  assign wss_take = i_wss_valid & (i_line_num == WSS_LINE) & state_reg.control[CTL_WSS_EN];

  // ****************************************
  // Flags set by hardware
  // ****************************************
  always_comb begin
    flag_set = '0;
    if (i_pkt_valid) begin
      if (i_pkt_num == PKT_PAGE_LINK && i_pkt_desig == DESIG_PAGE_LINK) begin
        // In 525 mode a packet with the tab bit set does not set the flag
        flag_set[FLG_PAGE_LINK] = ~state_reg.control[CTL_MODE_525] | ~i_pkt_tab;
      end
      if (i_pkt_num == PKT_SERVICE) begin
        if (state_reg.control[CTL_MODE_525]) begin
          // Only two magazine bits; all zero is magazine 4
          flag_set[FLG_SERVICE] = (i_pkt_mag[1:0] == MAG_SERVICE_525);
        end else begin
          flag_set[FLG_SERVICE] = (i_pkt_mag == MAG_SERVICE_625);
        end
      end
    end
    if (i_line_end && state_reg.line_state == LINE_VPS && state_reg.vps_got) begin
      flag_set[FLG_VPS_RCV] = 1'b1;
    end
    if (wss_take) begin
      flag_set[FLG_WSS_RCV] = 1'b1;
    end
  end

  // Set-beats-clear lives in one bank, shared by all four flags
  sticky_flag_bank #(
    .N(FLG_COUNT)
  ) u_flags (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_set(flag_set),
    .i_write(flag_write),
    .i_write_data(i_avs_writedata[FLG_COUNT-1:0]),
    .o_flags(flags)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.mem_we = 1'b0;
    state_next.irq = 1'b0;
    state_next.waitrequest = 1'b1;

    // Register bus: one wait cycle, read data captured alongside
    // Latching read data in the wait cycle lets it stand when waitrequest drops
    if (access && state_reg.waitrequest) begin
      state_next.waitrequest = 1'b0;
      state_next.readdata = '0;
      if (i_avs_read) begin
        case (i_avs_address)
          OFF_CONTROL: state_next.readdata = {27'h000_0000, state_reg.control};
          OFF_FLAGS: state_next.readdata = {28'h000_0000, flags};
          OFF_WIDESCREEN_A: state_next.readdata = {24'h00_0000, state_reg.wss_a};
          OFF_WIDESCREEN_B: state_next.readdata = {24'h00_0000, state_reg.wss_b};
          OFF_WIDESCREEN_C: state_next.readdata = {24'h00_0000, state_reg.wss_c};
          OFF_CAPTION_FIRST: state_next.readdata = {24'h00_0000, state_reg.cc_first};
          OFF_CAPTION_SECOND: state_next.readdata = {24'h00_0000, state_reg.cc_second};
          OFF_CAPTION_LINE: state_next.readdata = {27'h000_0000, state_reg.cc_line_sel};
          default: state_next.readdata = '0;
        endcase
      end
    end
    // Only byte lane 0 carries register bits
    if (done && i_avs_write && i_avs_byteenable[0]) begin
      case (i_avs_address)
        OFF_CONTROL: state_next.control = i_avs_writedata[CTL_WIDTH-1:0];
        OFF_CAPTION_LINE: state_next.cc_line_sel = i_avs_writedata[4:0];
        default: state_next.control = state_reg.control;
      endcase
    end

    // Widescreen: latched only while enabled, else left untouched
    if (wss_take) begin
      // All fourteen bits kept, split into three related groups
      state_next.wss_a = pack_group({2'b00, i_wss_bits[WSS_A_LO +: WSS_A_W]},
                                    |i_wss_err[WSS_A_LO +: WSS_A_W], WSS_A_W);
      state_next.wss_b = pack_group({2'b00, i_wss_bits[WSS_B_LO +: WSS_B_W]},
                                    |i_wss_err[WSS_B_LO +: WSS_B_W], WSS_B_W);
      state_next.wss_c = pack_group(i_wss_bits[WSS_C_LO +: WSS_C_W],
                                    |i_wss_err[WSS_C_LO +: WSS_C_W], WSS_C_W);
    end

    // Line sequencer
    // A second line start inside a line is ignored until its line end
    case (state_reg.line_state)
      LINE_IDLE: begin
        if (i_line_start) begin
          state_next.vps_col = '0;
          state_next.vps_got = 1'b0;
          state_next.cc_count = '0;
          if (is_vps_line && state_reg.control[CTL_VPS_EN]) begin
            state_next.line_state = LINE_VPS;
          end else if (is_cc_line && state_reg.control[CTL_CC_EN]) begin
            state_next.cc_first = 8'h00;
            state_next.cc_second = 8'h00;
            state_next.line_state = LINE_CAPTION;
          end else begin
            state_next.line_state = LINE_OTHER;
          end
        end
      end
      LINE_VPS: begin
        // Teletext on this line is left to the packet path
        if (i_byte_valid && i_runin_vps) begin
          state_next.mem_we = 1'b1;
          state_next.mem_col = state_reg.vps_col;
          state_next.mem_data = {3'b000, vps_dec};
          // Place travels with the write so every memory output leaves a flop
          state_next.mem_block = VPS_BLOCK;
          state_next.mem_row = VPS_ROW;
          // Column wraps after 2**COL_W bytes; a VPS line never carries that many
          state_next.vps_col = state_reg.vps_col + 1'b1;
          state_next.vps_got = 1'b1;
        end
        if (i_line_end) begin
          state_next.line_state = LINE_IDLE;
        end
      end
      LINE_CAPTION: begin
        if (i_byte_valid) begin
          // Caption bytes are stored raw; decoding them is left to software
          if (state_reg.cc_count == 2'd0) begin
            state_next.cc_first = i_byte;
            state_next.cc_count = 2'd1;
          end else if (state_reg.cc_count == 2'd1) begin
            state_next.cc_second = i_byte;
            state_next.cc_count = 2'd2;
          end
        end
        if (i_line_end) begin
          state_next.irq = state_reg.control[CTL_CC_IRQ_EN];
          state_next.line_state = LINE_IDLE;
        end
      end
      LINE_OTHER: begin
        if (i_line_end) begin
          state_next.line_state = LINE_IDLE;
        end
      end
      default: begin
        state_next.line_state = LINE_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  // Waitrequest starts high so no transfer can complete around reset release
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= '{
        control: CTL_RESET,
        cc_line_sel: CC_LINE_RESET,
        wss_a: 8'h00,
        wss_b: 8'h00,
        wss_c: 8'h00,
        cc_first: 8'h00,
        cc_second: 8'h00,
        cc_count: 2'd0,
        line_state: LINE_IDLE,
        vps_got: 1'b0,
        vps_col: '0,
        mem_we: 1'b0,
        mem_col: '0,
        mem_data: 8'h00,
        mem_block: 4'h0,
        mem_row: 5'h00,
        irq: 1'b0,
        readdata: 32'h0000_0000,
        waitrequest: 1'b1
      };
    end else if (i_clk_en) begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_avs_readdata = state_reg.readdata;
  assign o_avs_waitrequest = state_reg.waitrequest;
  assign o_mem_we = state_reg.mem_we;
  assign o_mem_block = state_reg.mem_block;
  assign o_mem_row = state_reg.mem_row;
  assign o_mem_col = state_reg.mem_col;
  assign o_mem_data = state_reg.mem_data;
  assign o_caption_irq = state_reg.irq;

endmodule

// >>> tb/vbi_side_data_capture_properties.sv
`timescale 1ns/100ps
// ****
// Capture checks
// ****
module vbi_side_data_capture_properties
  import vbi_capture_pkg::*;
#(
  parameter int COL_W = 6
) (
  // Clock, reset, bus
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Slicer side
  input wire logic i_line_end,
  input wire logic [8:0] i_line_num,
  input wire logic i_field,
  input wire logic i_runin_vps,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  // Memory port, irq
  input wire logic o_mem_we,
  input wire logic [3:0] o_mem_block,
  input wire logic [4:0] o_mem_row,
  input wire logic [COL_W-1:0] o_mem_col,
  input wire logic [7:0] o_mem_data,
  input wire logic o_caption_irq
);
  logic [3:0] chip_hi;
  logic [3:0] chip_lo;
  logic chip_bad;
  assign chip_hi = {i_byte[7], i_byte[5], i_byte[3], i_byte[1]};
  assign chip_lo = {i_byte[6], i_byte[4], i_byte[2], i_byte[0]};
  // Equal chips in a pair carry no biphase cell
  assign chip_bad = |(chip_hi ~^ chip_lo);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  property p_bus_ans; (i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en |=> !o_avs_waitrequest; endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer late");
  property p_bus_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_bus_one: assert property (p_bus_one) else $error("wait low too long");
  property p_vps_place; o_mem_we |-> o_mem_block == VPS_BLOCK && o_mem_row == VPS_ROW; endproperty
  a_vps_place: assert property (p_vps_place) else $error("vps place wrong");
  property p_vps_col; o_mem_we ##2 o_mem_we |-> o_mem_col == COL_W'($past(o_mem_col, 2) + 1'b1); endproperty
  a_vps_col: assert property (p_vps_col) else $error("vps column step");
  property p_vps_cause; o_mem_we |-> $past(i_byte_valid) && $past(i_runin_vps) && !$past(i_field)
    && $past(i_line_num) == VPS_LINE; endproperty
  a_vps_cause: assert property (p_vps_cause) else $error("vps write uncaused");
  property p_vps_byte; o_mem_we |-> o_mem_data == {3'b000, $past(chip_bad), $past(chip_hi)}; endproperty
  a_vps_byte: assert property (p_vps_byte) else $error("vps byte wrong");
  property p_irq_cause; o_caption_irq |-> $past(i_line_end); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without line end");
  property p_irq_pulse; o_caption_irq |=> !o_caption_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  c_vps: cover property (o_mem_we);
  c_irq: cover property (o_caption_irq);
  c_bus: cover property (!o_avs_waitrequest);
endmodule

bind vbi_side_data_capture vbi_side_data_capture_properties #(.COL_W(COL_W)) u_props (.*);

// >>> tb/vbi_slicer_model.sv
`timescale 1ns/100ps
// ****
// Slicer stand-in
// ****
module vbi_slicer_model
  import vbi_capture_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Line timing, bytes
  output logic o_line_start,
  output logic o_line_end,
  output logic [8:0] o_line_num,
  output logic o_field,
  output logic o_runin_vps,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  // Packet address
  output logic o_pkt_valid,
  output logic [2:0] o_pkt_mag,
  output logic o_pkt_tab,
  output logic [4:0] o_pkt_num,
  output logic [4:0] o_pkt_desig,
  // Widescreen word
  output logic o_wss_valid,
  output logic [13:0] o_wss_bits,
  output logic [13:0] o_wss_err
);
  initial begin
    {o_line_start, o_line_end, o_line_num, o_field, o_runin_vps, o_byte_valid, o_byte, o_pkt_valid} = '0;
    {o_pkt_mag, o_pkt_tab, o_pkt_num, o_pkt_desig, o_wss_valid, o_wss_bits, o_wss_err} = '0;
  end
  // Stale bytes are inverted so a late sample never matches
  task automatic line(input logic [8:0] num, input logic f, input logic v, input int n, input logic [31:0] b);
    @(posedge i_clock);
    o_line_num <= num;
    o_field <= f;
    o_runin_vps <= v;
    o_line_start <= 1'b1;
    @(posedge i_clock);
    o_line_start <= 1'b0;
    for (int k = 0; k < n; k++) begin
      @(posedge i_clock);
      o_byte_valid <= 1'b1;
      o_byte <= b[8*k+:8];
      @(posedge i_clock);
      o_byte_valid <= 1'b0;
      o_byte <= ~b[8*k+:8];
    end
    @(posedge i_clock);
    o_line_end <= 1'b1;
    @(posedge i_clock);
    o_line_end <= 1'b0;
    o_line_num <= 9'h000;
  endtask
  task automatic pkt(input logic [2:0] m, input logic t, input logic [4:0] p, input logic [4:0] d);
    @(posedge i_clock);
    o_pkt_valid <= 1'b1;
    {o_pkt_mag, o_pkt_tab, o_pkt_num, o_pkt_desig} <= {m, t, p, d};
    @(posedge i_clock);
    o_pkt_valid <= 1'b0;
  endtask
  task automatic wss(input logic [13:0] w, input logic [13:0] e);
    @(posedge i_clock);
    o_line_num <= WSS_LINE;
    o_wss_valid <= 1'b1;
    {o_wss_bits, o_wss_err} <= {w, e};
    @(posedge i_clock);
    o_wss_valid <= 1'b0;
    o_line_num <= 9'h000;
    o_wss_bits <= ~w;
  endtask
endmodule

// >>> tb/vbi_side_data_capture_tb_top.sv
`timescale 1ns/100ps
// ****
// Bench top
// ****
module vbi_side_data_capture_tb_top
  import vbi_capture_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = '0;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, i_line_start, i_line_end, i_field, i_runin_vps, i_byte_valid, i_pkt_valid;
  logic i_pkt_tab, i_wss_valid, o_mem_we, o_caption_irq;
  logic [8:0] i_line_num;
  logic [7:0] i_byte, o_mem_data;
  logic [2:0] i_pkt_mag;
  logic [4:0] i_pkt_num, i_pkt_desig, o_mem_row;
  logic [13:0] i_wss_bits, i_wss_err;
  logic [3:0] o_mem_block;
  logic [5:0] o_mem_col;
  logic [13:0] wq[$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int irqs = 0;
  always #2 i_clock = ~i_clock;
  vbi_side_data_capture dut (.*);
  vbi_slicer_model u_slicer (.i_clock(i_clock), .o_line_start(i_line_start), .o_line_end(i_line_end),
    .o_line_num(i_line_num), .o_field(i_field), .o_runin_vps(i_runin_vps), .o_byte_valid(i_byte_valid),
    .o_byte(i_byte), .o_pkt_valid(i_pkt_valid), .o_pkt_mag(i_pkt_mag), .o_pkt_tab(i_pkt_tab),
    .o_pkt_num(i_pkt_num), .o_pkt_desig(i_pkt_desig), .o_wss_valid(i_wss_valid), .o_wss_bits(i_wss_bits),
    .o_wss_err(i_wss_err));
  // Sampled mid-cycle so one-cycle pulses are seen settled
  always @(negedge i_clock) begin
    if (o_mem_we === 1'b1) wq.push_back({o_mem_col, o_mem_data});
    if (o_caption_irq === 1'b1) irqs++;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_writedata <= d;
    // Request holds until waitrequest is seen low at a rising edge; data taken there
    do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(n, e, q);
  endtask
  task automatic t_reset;
    rd("ctl", OFF_CONTROL, '0);
    rd("flg", OFF_FLAGS, '0);
    rd("ccsel", OFF_CAPTION_LINE, 32'h0000_0015);
    rd("unmap", 8'h20, '0);
    $display("reset test done");
  endtask
  task automatic t_flags;
    u_slicer.pkt(3'h2, 1'b1, 5'h1B, 5'h00);
    u_slicer.pkt(3'h0, 1'b0, 5'h1B, 5'h01);
    u_slicer.pkt(3'h4, 1'b0, 5'h1E, 5'h00);
    rd("link", OFF_FLAGS, 32'h0000_0001);
    u_slicer.pkt(3'h0, 1'b0, 5'h1E, 5'h00);
    rd("svc", OFF_FLAGS, 32'h0000_0003);
    wr(OFF_FLAGS, 32'h0000_00FE);
    rd("clr", OFF_FLAGS, 32'h0000_0002);
    wr(OFF_FLAGS, '0);
    wr(OFF_CONTROL, 32'h0000_0010);
    u_slicer.pkt(3'h0, 1'b1, 5'h1B, 5'h00);
    u_slicer.pkt(3'h1, 1'b0, 5'h1E, 5'h00);
    rd("tab", OFF_FLAGS, '0);
    u_slicer.pkt(3'h0, 1'b0, 5'h1B, 5'h00);
    u_slicer.pkt(3'h4, 1'b0, 5'h1E, 5'h00);
    rd("m4", OFF_FLAGS, 32'h0000_0003);
    wr(OFF_FLAGS, '0);
    // Packet pulse lands on the edge that completes the clearing write
    fork
      wr(OFF_FLAGS, '0);
      begin
        @(posedge i_clock);
        u_slicer.pkt(3'h0, 1'b0, 5'h1B, 5'h00);
      end
    join
    rd("setwin", OFF_FLAGS, 32'h0000_0001);
    wr(OFF_FLAGS, '0);
    $display("flag test done");
  endtask
  task automatic t_vps;
    wr(OFF_CONTROL, 32'h0000_0001);
    u_slicer.line(9'h010, 1'b0, 1'b1, 3, 32'h000F_5AA6);
    chk("vpsn", 32'h0000_0003, wq.size());
    chk("vps0", 32'h0000_000D, wq[0]);
    chk("vps1", 32'h0000_0103, wq[1]);
    chk("vps2", 32'h0000_0213, wq[2]);
    rd("vpsf", OFF_FLAGS, 32'h0000_0004);
    wr(OFF_FLAGS, '0);
    u_slicer.line(9'h010, 1'b1, 1'b1, 1, 32'h0000_00A6);
    u_slicer.line(9'h010, 1'b0, 1'b0, 1, 32'h0000_00A6);
    chk("vpsx", 32'h0000_0003, wq.size());
    rd("vpsf0", OFF_FLAGS, '0);
    $display("vps test done");
  endtask
  task automatic t_wss;
    u_slicer.wss(14'h2A5C, 14'h0100);
    rd("woff", OFF_WIDESCREEN_C, '0);
    wr(OFF_CONTROL, 32'h0000_0002);
    u_slicer.wss(14'h2A5C, 14'h0100);
    rd("wa", OFF_WIDESCREEN_A, 32'h0000_000C);
    rd("wb", OFF_WIDESCREEN_B, 32'h0000_0005);
    rd("wc", OFF_WIDESCREEN_C, 32'h0000_00AA);
    rd("wf", OFF_FLAGS, 32'h0000_0008);
    $display("widescreen test done");
  endtask
  task automatic t_cc;
    u_slicer.line(9'h015, 1'b0, 1'b0, 1, 32'h0000_0077);
    rd("cc0", OFF_CAPTION_FIRST, '0);
    wr(OFF_CONTROL, 32'h0000_000C);
    u_slicer.line(9'h015, 1'b0, 1'b0, 3, 32'h0043_4241);
    rd("cc1", OFF_CAPTION_FIRST, 32'h0000_0041);
    rd("cc2", OFF_CAPTION_SECOND, 32'h0000_0042);
    wr(OFF_CAPTION_LINE, 32'h0000_0012);
    wr(OFF_CONTROL, 32'h0000_0004);
    u_slicer.line(9'h012, 1'b1, 1'b0, 1, 32'h0000_0055);
    rd("cc3", OFF_CAPTION_SECOND, '0);
    rd("cc4", OFF_CAPTION_FIRST, 32'h0000_0055);
    chk("irq", 32'h0000_0001, irqs);
    $display("caption test done");
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_flags();
    t_vps();
    t_wss();
    t_cc();
    report_and_stop();
  end
endmodule
